/* src/lmrb_bank.v */
// Chosen here: register access over AXI4-Lite.
`include "lmrb_regs.vh"

module lmrb_bank #(
    parameter NUM_Q = 6
) (
    // Clock and reset
    input  wire                 aclk,
    input  wire                 aresetn,
    // AXI4-Lite write address
    input  wire [11:0]          s_axi_awaddr,
    input  wire [2:0]           s_axi_awprot,
    input  wire                 s_axi_awvalid,
    output reg                  s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0]          s_axi_wdata,
    input  wire [3:0]           s_axi_wstrb,
    input  wire                 s_axi_wvalid,
    output reg                  s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]           s_axi_bresp,
    output reg                  s_axi_bvalid,
    input  wire                 s_axi_bready,
    // AXI4-Lite read address
    input  wire [11:0]          s_axi_araddr,
    input  wire [2:0]           s_axi_arprot,
    input  wire                 s_axi_arvalid,
    output reg                  s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0]          s_axi_rdata,
    output reg  [1:0]           s_axi_rresp,
    output reg                  s_axi_rvalid,
    input  wire                 s_axi_rready,
    // Measurements from the analog path
    input  wire [8*NUM_Q-1:0]   transistor_power_in,
    input  wire                 loop_voltage_sign_in,
    input  wire [5:0]           loop_voltage_magnitude_in,
    input  wire                 loop_current_sign_in,
    input  wire [5:0]           loop_current_magnitude_in,
    input  wire [7:0]           tip_voltage_in,
    input  wire [7:0]           ring_voltage_in,
    // Settings toward converter and monitor
    output reg  [5:0]           low_battery_level,
    output reg  [2:0]           power_monitor_select_field,
    output reg                  power_scale_fine
);

    localparam MEAS_W = 8 * NUM_Q + 30;

    // ------------------------------------------------------------------
    // Measurement capture
    // ------------------------------------------------------------------
    wire [MEAS_W-1:0] meas_raw;
    wire [MEAS_W-1:0] meas_sync;
    reg  [MEAS_W-1:0] meas_prev_r;
    reg  [MEAS_W-1:0] meas_r;

    assign meas_raw = {transistor_power_in,
                       loop_voltage_sign_in, loop_voltage_magnitude_in,
                       loop_current_sign_in, loop_current_magnitude_in,
                       tip_voltage_in, ring_voltage_in};

    lmrb_sync #(
        .WIDTH (MEAS_W)
    ) u_meas_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       (meas_raw),
        .q       (meas_sync)
    );

    // Bus of asynchronous bits: take it only once two samples agree,
    // so a word caught mid-change never reaches software.
    always @(posedge aclk) begin
        if (!aresetn) begin
            meas_prev_r <= {MEAS_W{1'b0}};
            meas_r      <= {MEAS_W{1'b0}};
        end else begin
            meas_prev_r <= meas_sync;
            if (meas_sync == meas_prev_r) begin
                meas_r <= meas_sync;
            end
        end
    end

    wire [8*NUM_Q-1:0] power_all   = meas_r[MEAS_W-1 -: 8*NUM_Q];
    wire               lv_sign     = meas_r[29];
    wire [5:0]         lv_mag      = meas_r[28:23];
    wire               lc_sign     = meas_r[22];
    wire [5:0]         lc_mag      = meas_r[21:16];
    wire [7:0]         tip_v       = meas_r[15:8];
    wire [7:0]         ring_v      = meas_r[7:0];

    // ------------------------------------------------------------------
    // Power channel select
    // ------------------------------------------------------------------
    reg [7:0] power_out_nxt;
    reg       power_scale_nxt;

    // Undefined select codes read zero rather than stale data
    always @* begin
        power_out_nxt   = `LMRB_RST_MEAS8;
        power_scale_nxt = 1'b0;
        if (power_monitor_select_field <= `LMRB_SEL_LAST) begin
            power_out_nxt = power_all[power_monitor_select_field*8 +: 8];
        end
        // Q3 and Q4 are the small parts: fine scale, all others coarse
        if (power_monitor_select_field == `LMRB_SEL_Q3) begin
            power_scale_nxt = 1'b1;
        end else if (power_monitor_select_field == `LMRB_SEL_Q4) begin
            power_scale_nxt = 1'b1;
        end else begin
            power_scale_nxt = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Measurement registers
    // ------------------------------------------------------------------
    reg [7:0] power_out_r;
    reg       lv_sign_r;
    reg [5:0] lv_mag_r;
    reg       lc_sign_r;
    reg [5:0] lc_mag_r;
    reg [7:0] tip_v_r;
    reg [7:0] ring_v_r;

    always @(posedge aclk) begin
        if (!aresetn) begin
            power_out_r      <= `LMRB_RST_MEAS8;
            lv_sign_r        <= 1'b0;
            lv_mag_r         <= `LMRB_RST_MAG6;
            lc_sign_r        <= 1'b0;
            lc_mag_r         <= `LMRB_RST_MAG6;
            tip_v_r          <= `LMRB_RST_MEAS8;
            ring_v_r         <= `LMRB_RST_MEAS8;
            power_scale_fine <= 1'b0;
        end else begin
            // Registered again so a select change and its reading land together
            power_out_r      <= power_out_nxt;
            // Tells the analog path which full scale to apply
            power_scale_fine <= power_scale_nxt;
            lv_sign_r <= lv_sign;
            lv_mag_r  <= lv_mag;
            lc_sign_r <= lc_sign;
            lc_mag_r  <= lc_mag;
            tip_v_r   <= tip_v;
            ring_v_r  <= ring_v;
        end
    end

    // ------------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------------
    reg  [9:0] wr_idx_r;
    reg        aw_held_r;
    reg        w_held_r;
    reg [31:0] wdata_r;
    reg        wlane0_r;

    // Ready high at idle: a lone AW or W is taken at once and parked
    wire aw_hs  = s_axi_awvalid && s_axi_awready;
    wire w_hs   = s_axi_wvalid && s_axi_wready;
    // Commit waits for the old response to leave, so bresp never moves under bvalid
    wire commit = aw_held_r && w_held_r && !s_axi_bvalid;

    // Decoded once so the response and the settings agree on the map
    wire wr_in_map  = (wr_idx_r >= `LMRB_IDX_LOW_BAT) && (wr_idx_r <= `LMRB_IDX_RING_V);
    wire wr_low_bat = (wr_idx_r == `LMRB_IDX_LOW_BAT);
    wire wr_pwr_sel = (wr_idx_r == `LMRB_IDX_PWR_SEL);

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `LMRB_RESP_OKAY;
            aw_held_r     <= 1'b0;
            w_held_r      <= 1'b0;
            wr_idx_r      <= 10'h000;
            wdata_r       <= 32'h00000000;
            wlane0_r      <= 1'b0;
        end else begin
            if (aw_hs) begin
                aw_held_r     <= 1'b1;
                s_axi_awready <= 1'b0;
                wr_idx_r      <= s_axi_awaddr[11:2];
            end
            if (w_hs) begin
                w_held_r     <= 1'b1;
                s_axi_wready <= 1'b0;
                wdata_r      <= s_axi_wdata;
                // Only lane 0 holds a field; upper lanes carry reserved bits
                wlane0_r     <= s_axi_wstrb[0];
            end
            if (commit) begin
                aw_held_r     <= 1'b0;
                w_held_r      <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
                s_axi_bvalid  <= 1'b1;
                if (wr_in_map) begin
                    s_axi_bresp <= `LMRB_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `LMRB_RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Writable settings
    // ------------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            low_battery_level          <= `LMRB_RST_LOW_BAT;
            power_monitor_select_field <= `LMRB_RST_PWR_SEL;
        end else if (commit && wlane0_r) begin
            // No ordering check against the high level; software owns it
            // In-map writes with lane 0 off still answer OKAY but change nothing
            if (wr_low_bat) begin
                low_battery_level <= wdata_r[`LMRB_LOW_BAT_MSB:0];
            end else if (wr_pwr_sel) begin
                power_monitor_select_field <= wdata_r[`LMRB_PWR_SEL_MSB:0];
            end
            // Measurement indices fall through untouched
        end
    end

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    wire [9:0] rd_idx = s_axi_araddr[11:2];
    reg [31:0] rd_data;
    reg        rd_err;

    // Reserved bits tied low here so every path reads them as zero
    wire [31:0] word_low_bat = {26'h0, low_battery_level};
    wire [31:0] word_pwr_sel = {29'h0, power_monitor_select_field};
    wire [31:0] word_pwr_out = {24'h0, power_out_r};
    wire [31:0] word_loop_v  = {25'h0, lv_sign_r, lv_mag_r};
    wire [31:0] word_loop_i  = {25'h0, lc_sign_r, lc_mag_r};
    wire [31:0] word_tip_v   = {24'h0, tip_v_r};
    wire [31:0] word_ring_v  = {24'h0, ring_v_r};

    always @* begin
        rd_data = 32'h00000000;
        rd_err  = 1'b0;
        if (rd_idx == `LMRB_IDX_LOW_BAT) begin
            rd_data = word_low_bat;
        end else if (rd_idx == `LMRB_IDX_PWR_SEL) begin
            rd_data = word_pwr_sel;
        end else if (rd_idx == `LMRB_IDX_PWR_OUT) begin
            rd_data = word_pwr_out;
        end else if (rd_idx == `LMRB_IDX_LOOP_V) begin
            rd_data = word_loop_v;
        end else if (rd_idx == `LMRB_IDX_LOOP_I) begin
            rd_data = word_loop_i;
        end else if (rd_idx == `LMRB_IDX_TIP_V) begin
            rd_data = word_tip_v;
        end else if (rd_idx == `LMRB_IDX_RING_V) begin
            rd_data = word_ring_v;
        end else begin
            rd_err = 1'b1;
        end
    end

    // Address sampled only at the handshake; arready low holds off a second read
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `LMRB_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_data;
                s_axi_rresp   <= rd_err ? `LMRB_RESP_SLVERR : `LMRB_RESP_OKAY;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule // lmrb_bank

/* src/lmrb_regs.vh */
`ifndef LMRB_REGS_VH
`define LMRB_REGS_VH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define LMRB_IDX_LOW_BAT        10'h04B
`define LMRB_IDX_PWR_SEL        10'h04C
`define LMRB_IDX_PWR_OUT        10'h04D
`define LMRB_IDX_LOOP_V         10'h04E
`define LMRB_IDX_LOOP_I         10'h04F
`define LMRB_IDX_TIP_V          10'h050
`define LMRB_IDX_RING_V         10'h051

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define LMRB_RST_LOW_BAT        6'h10
`define LMRB_RST_PWR_SEL        3'h0
`define LMRB_RST_MEAS8          8'h00
`define LMRB_RST_MAG6           6'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define LMRB_LOW_BAT_MSB        5
`define LMRB_PWR_SEL_MSB        2
`define LMRB_SIGN_BIT           6
`define LMRB_MAG_MSB            5

// ----------------------------------------------------------------------
// Select codes
// ----------------------------------------------------------------------
`define LMRB_SEL_Q3             3'h2
`define LMRB_SEL_Q4             3'h3
`define LMRB_SEL_LAST           3'h5

// ----------------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------------
`define LMRB_RESP_OKAY          2'h0
`define LMRB_RESP_SLVERR        2'h2

`endif

/* src/lmrb_sync.v */
module lmrb_sync #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input  wire             aclk,
    input  wire             aresetn,
    // Data
    input  wire [WIDTH-1:0] d,
    output wire [WIDTH-1:0] q
);

    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] sync_r;

    always @(posedge aclk) begin
        if (!aresetn) begin
            meta_r <= {WIDTH{1'b0}};
            sync_r <= {WIDTH{1'b0}};
        end else begin
            meta_r <= d;
            sync_r <= meta_r;
        end
    end

    assign q = sync_r;

endmodule // lmrb_sync

/* testbench/lmrb_bank_chk.sv */
`include "lmrb_regs.vh"
module lmrb_chk #(
    parameter NUM_Q = 6
) (
    // Clock and reset
    input logic        aclk,
    input logic        aresetn,
    // Bus
    input logic        s_axi_awvalid,
    input logic        s_axi_awready,
    input logic        s_axi_wvalid,
    input logic        s_axi_wready,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic [1:0]  s_axi_bresp,
    input logic [11:0] s_axi_araddr,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic [31:0] s_axi_rdata,
    input logic [1:0]  s_axi_rresp,
    // Settings
    input logic [5:0]  low_battery_level,
    input logic [2:0]  power_monitor_select_field,
    input logic        power_scale_fine
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read not answered");
    a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && !s_axi_bvalid |-> ##2 s_axi_bvalid) else $error("write not answered");
    a_rsv_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_bad_read: assert property (s_axi_arvalid && s_axi_arready && (s_axi_araddr[11:2] <
        `LMRB_IDX_LOW_BAT || s_axi_araddr[11:2] > `LMRB_IDX_RING_V) |=> s_axi_rresp ==
        `LMRB_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read accepted");
    a_fine_scale: assert property (
        power_scale_fine == ($past(power_monitor_select_field) == `LMRB_SEL_Q3 ||
        $past(power_monitor_select_field) == `LMRB_SEL_Q4)) else $error("scale select wrong");
    a_set_cause: assert property (
        !$stable(low_battery_level) || !$stable(power_monitor_select_field)
        |-> $rose(s_axi_bvalid)) else $error("setting changed without write");
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_slverr: cover property (s_axi_rvalid && s_axi_rresp == `LMRB_RESP_SLVERR);
    c_fine: cover property (power_scale_fine);
endmodule // lmrb_chk
bind lmrb_bank lmrb_chk #(.NUM_Q(NUM_Q)) chk_u (.*);

/* testbench/lmrb_tb.sv */
`include "lmrb_regs.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk = 1'h0, aresetn = 1'h0;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd, d;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic [47:0] transistor_power_in = 48'h0;
    logic        loop_voltage_sign_in = 1'h0, loop_current_sign_in = 1'h0;
    logic [5:0]  loop_voltage_magnitude_in = 6'h0, loop_current_magnitude_in = 6'h0;
    logic [7:0]  tip_voltage_in = 8'h0, ring_voltage_in = 8'h0;
    logic [5:0]  low_battery_level, lb_m;
    logic [2:0]  power_monitor_select_field, sel_m;
    logic        power_scale_fine;
    logic [95:0] rv;
    int          failures = 0, checked = 0, cycles = 0;

    lmrb_bank #(.NUM_Q(6)) dut_u (.*);

    always #5 aclk = ~aclk;
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            stop_test();
        end
    end
    // ----------------------------------------
    // Bus tasks and expectations
    // ----------------------------------------
    task chk(string n, logic [31:0] e, logic [31:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task wr(logic [9:0] i, logic [31:0] v, logic [3:0] s);
        @(posedge aclk);
        s_axi_awaddr <= {i, 2'h0};
        s_axi_wdata <= v;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task rdr(logic [9:0] i);
        @(posedge aclk);
        s_axi_araddr <= {i, 2'h0};
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    function logic [31:0] ex(int k);
        case (k)
            0: ex = {26'h0, lb_m};
            1: ex = {29'h0, sel_m};
            2: ex = sel_m < 3'h6 ? {24'h0, transistor_power_in[sel_m*8 +: 8]} : 32'h0;
            3: ex = {25'h0, loop_voltage_sign_in, loop_voltage_magnitude_in};
            4: ex = {25'h0, loop_current_sign_in, loop_current_magnitude_in};
            5: ex = {24'h0, tip_voltage_in};
            default: ex = {24'h0, ring_voltage_in};
        endcase
    endfunction
    task rd_all;
        for (int k = 0; k < 7; k++) begin
            rdr(`LMRB_IDX_LOW_BAT + 10'(k));
            chk("reg", ex(k), rd);
            chk("rresp", 32'h0, {30'h0, rsp});
        end
    endtask
    task stop_test;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        void'($urandom(40216));
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        lb_m = 6'h10;
        sel_m = 3'h0;
        rd_all();
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            d = $urandom;
            if (i == 0) d[5:0] = 6'h3F;
            // High level lives outside the block; keeping it above is ours
            wr(`LMRB_IDX_LOW_BAT, d, 4'hF);
            lb_m = d[5:0];
            d = $urandom;
            d[2:0] = 3'(i);
            wr(`LMRB_IDX_PWR_SEL, d, 4'hF);
            sel_m = 3'(i);
            rv = {$urandom, $urandom, $urandom};
            {transistor_power_in, loop_voltage_sign_in, loop_voltage_magnitude_in,
                loop_current_sign_in, loop_current_magnitude_in, tip_voltage_in,
                ring_voltage_in} <= rv[77:0];
            repeat (8) @(posedge aclk);
            rd_all();
            chk("fine", {31'h0, sel_m == 3'h2 || sel_m == 3'h3}, {31'h0, power_scale_fine});
            chk("lbl", {26'h0, lb_m}, {26'h0, low_battery_level});
            chk("sel", {29'h0, sel_m}, {29'h0, power_monitor_select_field});
        end
        $display("test random done");
        for (int k = 2; k < 7; k++) begin
            wr(`LMRB_IDX_LOW_BAT + 10'(k), $urandom, 4'hF);
            chk("bresp", 32'h0, {30'h0, rsp});
        end
        wr(`LMRB_IDX_LOW_BAT, {26'h0, ~lb_m}, 4'h0);
        chk("bresp", 32'h0, {30'h0, rsp});
        wr(10'h04A, 32'h0, 4'hF);
        chk("bresp", 32'h2, {30'h0, rsp});
        rdr(10'h052);
        chk("rresp", 32'h2, {30'h0, rsp});
        chk("rdata", 32'h0, rd);
        rd_all();
        $display("test refused done");
        stop_test();
    end
endmodule // tb_top
